// File: verilog/pci_read_fifo_target_ctl.sv
// Purpose: master read data fifo port and target general controls of the pci core
// Assumes: one clock; fabric and pci rates arrive as one-cycle enable pulses
// Notes: all inputs are synchronous to clk
// Operation
// - pop low presents next read word
// - read data 16 bits quad, 32 dual
// - almost empty low at four words left
// - empty low while fifo holds nothing
// - burst stop acts only during transfer
// - fifo clear empties target state
// - clear leaves pci state machine alone
// - ready low in reset, clear, startup
// - four-bit target state count output
// - retry low retries following target cycles
// - delayed low makes reads delayed transactions
// - fifo clock chosen from two fabric clocks
`timescale 1ns/1ps
`include "pci_fabric_map.svh"

module pci_read_fifo_target_ctl
    import pci_fabric_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // rate enables
    input wire logic fabric_clock_a,
    input wire logic fabric_clock_b,
    input wire logic pciClkEn,
    // pci core side of the read fifo
    input wire logic pciRstN,
    input wire logic fillValid,
    input wire logic [63:0] fillData,
    input wire logic fillLast,
    output logic fillReady,
    input wire logic masterTransferring,
    output logic burstStopReq,
    // user read port
    input wire logic master_read_pop_n,
    input wire logic fifo_select,
    output logic [17:0] quadReadData,
    output logic [31:0] dualReadData,
    output logic [3:0] dualReadDataX,
    output logic master_read_empty_n,
    output logic master_read_almost_empty_n,
    output logic master_read_last_n,
    // user command word for read burst length
    input wire logic cmdValid,
    input wire logic [17:0] cmdQuad,
    input wire logic [3:0] cmdDualX,
    input wire logic [31:0] cmdDual,
    output logic [17:0] burstLength,
    output logic burstLengthValid,
    // pci stop and target controls
    input wire logic read_burst_stop_n,
    input wire logic target_retry_n,
    input wire logic delayed_txn_n,
    output logic retryActive,
    output logic delayedActive,
    // target fifo interface
    input wire logic target_fifo_clear_n,
    input wire logic targetPendN,
    input wire logic targetStep,
    input wire logic targetDone,
    output logic target_side_ready,
    output logic [3:0] target_state_count
);

    localparam int PW = $clog2(DEPTH);

    // whole module state in one word
    typedef struct packed
    {
        logic [DEPTH-1:0][63:0] mem;   // read fifo storage
        logic [DEPTH-1:0] lastMem;     // last-word marks
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;            // words held
        logic [1:0] part;              // portion of head word
        logic [17:0] quadData;
        logic [31:0] dualData;
        logic lastN;
        logic quadMode;
        logic clkSel;
        logic cmdHiPending;            // quad upper bits taken
        logic [1:0] cmdHi;
        logic [17:0] burstLen;
        logic burstValid;
        logic [1:0] stopTicks;
        logic stopReq;
        logic retry;
        logic delayed;
        target_state_e tState;
        logic [4:0] readyCnt;
        logic ready;
        logic [31:0] rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // one portion of a 64-bit word in the active width
    function automatic logic [31:0] portionOf(input logic [63:0] word, input logic [1:0] part,
                                              input logic quad);
        // quad portions sit zero-extended in the low half
        return quad ? 32'(word[16*part +: 16]) : word[32*part[0] +: 32];
    endfunction

    // fabric rate and derived strobes
    logic fabricTick;
    logic popNow;
    logic partEnd;
    logic wrNow;
    logic fifoFull;

    // fill and drain strobes
    always_comb
    begin
        fabricTick = state_reg.clkSel ? fabric_clock_b : fabric_clock_a;
        fifoFull = (state_reg.count == (PW+1)'(DEPTH));
        popNow = fabricTick && !master_read_pop_n && (state_reg.count != '0);
        partEnd = state_reg.part == (state_reg.quadMode ? `QUAD_LAST_PART : `DUAL_LAST_PART);
        wrNow = pciClkEn && fillValid && !fifoFull;
    end

    // next state
    always_comb
    begin
        logic [63:0] head;
        logic [31:0] slice;
        head = state_reg.mem[state_reg.rdPtr];
        slice = '0;
        state_next = state_reg;

        // register writes steer mode and clock choice
        if (regWrite && regAddr == `ADDR_CTRL)
        begin
            state_next.quadMode = regWdata[`CTRL_QUAD_BIT];
            state_next.clkSel = regWdata[`CTRL_CLKSEL_BIT];
        end

        // fifo write from the pci side
        if (wrNow)
        begin
            state_next.mem[state_reg.wrPtr] = fillData;
            state_next.lastMem[state_reg.wrPtr] = fillLast;
            state_next.wrPtr = state_reg.wrPtr + PW'(1);
        end

        if (popNow)
        begin
            slice = portionOf(head, state_reg.part, state_reg.quadMode);
            // width by mode, top bits zero
            state_next.quadData = {2'h0, slice[15:0]};
            state_next.dualData = slice;
            state_next.lastN = !(partEnd && state_reg.lastMem[state_reg.rdPtr]);
            if (partEnd)
            begin
                state_next.part = 2'h0;
                state_next.rdPtr = state_reg.rdPtr + PW'(1);
            end
            else
            begin
                state_next.part = state_reg.part + 2'h1;
            end
        end
        else if (fabricTick)
        begin
            // last marks one word only
            state_next.lastN = 1'b1;
        end

        // occupancy in whole words
        state_next.count = state_reg.count + (PW+1)'(wrNow) - (PW+1)'(popNow && partEnd);

        state_next.burstValid = 1'b0;
        if (fabricTick && cmdValid)
        begin
            if (!state_reg.quadMode)
            begin
                state_next.burstLen = {cmdDualX[1:0], cmdDual[15:0]};
                state_next.burstValid = 1'b1;
            end
            else if (!state_reg.cmdHiPending)
            begin
                state_next.cmdHi = cmdQuad[17:16];
                state_next.cmdHiPending = 1'b1;
            end
            else
            begin
                state_next.burstLen = {state_reg.cmdHi, cmdQuad[15:0]};
                state_next.burstValid = 1'b1;
                state_next.cmdHiPending = 1'b0;
            end
        end

        // pci-rate controls
        if (pciClkEn)
        begin
            if (read_burst_stop_n)
            begin
                state_next.stopTicks = 2'h0;
            end
            else if (state_reg.stopTicks != `STOP_HOLD_TICKS)
            begin
                state_next.stopTicks = state_reg.stopTicks + 2'h1;
            end
            state_next.stopReq = !read_burst_stop_n && masterTransferring;
            state_next.retry = !target_retry_n;
            // held value taken at pci rate
            state_next.delayed = !delayed_txn_n;
        end

        if (fabricTick && state_reg.readyCnt != `READY_DELAY_TICKS)
        begin
            state_next.readyCnt = state_reg.readyCnt + 5'h1;
        end
        state_next.ready = (state_next.readyCnt == `READY_DELAY_TICKS) && pciRstN
            && target_fifo_clear_n;

        // target fifo interface walk
        if (fabricTick)
        begin
            case (state_reg.tState)
                T_IDLE:
                begin
                    if (!targetPendN)
                    begin
                        state_next.tState = T_ADDR;
                    end
                end
                T_ADDR:
                begin
                    if (targetStep)
                    begin
                        state_next.tState = T_DATA;
                    end
                end
                T_DATA:
                begin
                    if (targetDone)
                    begin
                        state_next.tState = T_LAST;
                    end
                end
                T_LAST:
                begin
                    state_next.tState = T_IDLE;
                end
                default:
                begin
                    state_next.tState = T_IDLE;
                end
            endcase
        end
        if (!target_fifo_clear_n)
        begin
            state_next.tState = T_IDLE;
        end

        // register reads, answer next cycle
        state_next.rdata = 32'h0;
        if (regRead)
        begin
            case (regAddr)
                `ADDR_CTRL:
                begin
                    state_next.rdata[`CTRL_QUAD_BIT] = state_reg.quadMode;
                    state_next.rdata[`CTRL_CLKSEL_BIT] = state_reg.clkSel;
                end
                `ADDR_STATUS:
                begin
                    state_next.rdata[`STAT_EMPTY_BIT] = master_read_empty_n;
                    state_next.rdata[`STAT_AEMPTY_BIT] = master_read_almost_empty_n;
                    state_next.rdata[`STAT_LAST_BIT] = state_reg.lastN;
                    state_next.rdata[`STAT_STOP_BIT] = state_reg.stopReq;
                    state_next.rdata[`STAT_RETRY_BIT] = state_reg.retry;
                    state_next.rdata[`STAT_DELAYED_BIT] = state_reg.delayed;
                    state_next.rdata[`STAT_READY_BIT] = state_reg.ready;
                    state_next.rdata[`STAT_COUNT_LSB +: PW+1] = state_reg.count;
                end
                `ADDR_BURST:
                begin
                    state_next.rdata[17:0] = state_reg.burstLen;
                end
                `ADDR_TARGET:
                begin
                    state_next.rdata[3:0] = state_reg.tState;
                end
                default:
                begin
                    // unmapped reads as zero, cleared above
                end
            endcase
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
            state_reg.lastN <= 1'b1;
            state_reg.quadMode <= 1'(`CTRL_RESET);
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs
    always_comb
    begin
        regRdata = state_reg.rdata;
        fillReady = !fifoFull;
        quadReadData = state_reg.quadData;
        // dual bus carries read data only with fifo_select low
        dualReadData = fifo_select ? 32'h0 : state_reg.dualData;
        dualReadDataX = 4'h0;
        master_read_empty_n = (state_reg.count != '0);
        master_read_almost_empty_n = (state_reg.count > (PW+1)'(`ALMOST_EMPTY_WORDS));
        master_read_last_n = state_reg.lastN;
        burstLength = state_reg.burstLen;
        burstLengthValid = state_reg.burstValid;
        burstStopReq = state_reg.stopReq && (state_reg.stopTicks == `STOP_HOLD_TICKS);
        retryActive = state_reg.retry;
        delayedActive = state_reg.delayed;
        target_side_ready = state_reg.ready && pciRstN && target_fifo_clear_n;
        target_state_count = target_fifo_clear_n ? state_reg.tState : 4'h0;
    end

endmodule

// File: verilog/pci_fabric_map.svh
// Purpose: named offsets, field positions, reset values and timing counts
// Assumes: included by its bare name wherever the names are needed
// Notes: definitions only, no logic
`ifndef PCI_FABRIC_MAP_SVH
`define PCI_FABRIC_MAP_SVH

// register word offsets on the plain register port
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_BURST 4'h8
`define ADDR_TARGET 4'hC

// control register fields
`define CTRL_QUAD_BIT 0
`define CTRL_CLKSEL_BIT 1
`define CTRL_RESET 2'h1

// status register fields
`define STAT_EMPTY_BIT 0
`define STAT_AEMPTY_BIT 1
`define STAT_LAST_BIT 2
`define STAT_STOP_BIT 3
`define STAT_RETRY_BIT 4
`define STAT_DELAYED_BIT 5
`define STAT_READY_BIT 6
`define STAT_COUNT_LSB 8

// flag thresholds in 64-bit words
`define ALMOST_EMPTY_WORDS 4

// pci ticks a stop request must stand before it acts
`define STOP_HOLD_TICKS 2'h2

// fabric ticks the target side stays not ready after reset
`define READY_DELAY_TICKS 5'h10

// last 16-bit and 32-bit portion index of a 64-bit word
`define QUAD_LAST_PART 2'h3
`define DUAL_LAST_PART 2'h1

`endif

// File: verilog/pci_fabric_pkg.sv
// Purpose: shared types of the pci fabric read fifo and target control
// Assumes: nothing beyond the map header for numbers
// Notes: types only
package pci_fabric_pkg;

    // target fifo interface state, gray along the usual path
    typedef enum logic [3:0]
    {
        T_IDLE = 4'h0,
        T_ADDR = 4'h1,
        T_DATA = 4'h3,
        T_LAST = 4'h2
    } target_state_e;

endpackage

// File: test/read_fifo_monitor.sv
// Purpose: port-level checks of the read fifo and target controls
// Assumes: pci enable held high by the bench, fabric tick too except while t_burst selects idle clock b
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ps
module read_fifo_monitor
#(
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // read fifo
    input wire logic pciClkEn,
    input wire logic fillValid,
    input wire logic fillReady,
    input wire logic master_read_pop_n,
    input wire logic [17:0] quadReadData,
    input wire logic master_read_empty_n,
    input wire logic master_read_almost_empty_n,
    input wire logic master_read_last_n,
    // pci controls
    input wire logic read_burst_stop_n,
    input wire logic burstStopReq,
    input wire logic target_retry_n,
    input wire logic delayed_txn_n,
    input wire logic retryActive,
    input wire logic delayedActive,
    // target side
    input wire logic pciRstN,
    input wire logic target_fifo_clear_n,
    input wire logic target_side_ready,
    input wire logic [3:0] target_state_count
);
    // one domain, so clock and reset are given once
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_fill_nonempty: assert property (
        pciClkEn && fillValid && fillReady |=> master_read_empty_n)
        else $error("read fifo empty after a fill");
    a_empty_implies_low: assert property (
        !master_read_empty_n |-> !master_read_almost_empty_n)
        else $error("almost empty high on an empty fifo");
    a_quad_top_zero: assert property (
        quadReadData[17:16] == 2'h0)
        else $error("unused read bits driven");
    a_last_with_pop: assert property (
        $fell(master_read_last_n) |-> !$past(master_read_pop_n))
        else $error("last marker without a pop");
    a_stop_two_ticks: assert property (
        $rose(burstStopReq) |-> !$past(read_burst_stop_n) && !$past(read_burst_stop_n, 2))
        else $error("burst stop acted on a short request");
    a_retry_follows: assert property (
        pciClkEn && !target_retry_n |=> retryActive)
        else $error("retry request not taken");
    a_delayed_follows: assert property (
        pciClkEn && delayed_txn_n |=> !delayedActive)
        else $error("delayed mode without request");
    a_clear_empties: assert property (
        !target_fifo_clear_n |-> target_state_count == 4'h0 && !target_side_ready)
        else $error("target state kept through a clear");
    a_pci_reset_ready: assert property (
        !pciRstN |-> !target_side_ready)
        else $error("ready during pci reset");
    a_ready_startup: assert property (
        $rose(target_side_ready) |-> $past(rst_n, 16))
        else $error("ready too soon after reset");
endmodule

// File: test/user_read_model.sv
// Purpose: user logic that pops the master read fifo
// Assumes: fabric tick every cycle
// Notes: pops on alternate cycles so the empty flag it sees is fresh
`timescale 1ns/1ps
module user_read_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench control
    input wire logic popEn,
    // read fifo flag and pop
    input wire logic master_read_empty_n,
    output logic master_read_pop_n
);
    always_ff @(posedge clk)
    begin
        if (!rst_n || !master_read_pop_n)
            master_read_pop_n <= 1'h1;
        else
            master_read_pop_n <= !(popEn && master_read_empty_n);
    end
endmodule

// File: test/tb.sv
// Purpose: self-checking bench of the read fifo and target controls
// Assumes: pci enable high every cycle, fabric tick too except while t_burst selects idle clock b
// Notes: register port used for mode and status
`timescale 1ns/1ps
`include "pci_fabric_map.svh"
module tb;
    parameter int DEPTH = 16;
    logic clk, rst_n, regWrite, regRead, fabric_clock_a, fabric_clock_b, pciClkEn;
    logic [3:0] regAddr, dualReadDataX, cmdDualX, target_state_count;
    logic [31:0] regWdata, regRdata, dualReadData, cmdDual, d;
    logic pciRstN, fillValid, fillLast, fillReady, masterTransferring, burstStopReq;
    logic [63:0] fillData, w;
    logic master_read_pop_n, fifo_select, master_read_empty_n, master_read_almost_empty_n;
    logic master_read_last_n, cmdValid, burstLengthValid, read_burst_stop_n;
    logic [17:0] quadReadData, cmdQuad, burstLength;
    logic target_retry_n, delayed_txn_n, retryActive, delayedActive, popEn, took;
    logic target_fifo_clear_n, targetPendN, targetStep, targetDone, target_side_ready;
    logic [50:0] log_q[$];
    int num_errors, total_checks;

    pci_read_fifo_target_ctl #(.DEPTH(DEPTH)) pci_read_fifo_target_ctl_i (.*);
    user_read_model user_read_model_i (.clk(clk), .rst_n(rst_n), .popEn(popEn),
        .master_read_empty_n(master_read_empty_n), .master_read_pop_n(master_read_pop_n));

    // 200 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // log what each taken pop presented, a cycle after the take
    always @(posedge clk)
    begin
        if (took)
            log_q.push_back({master_read_last_n, quadReadData, dualReadData});
        took <= rst_n && !master_read_pop_n && master_read_empty_n;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regWrite <= 1'h1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'h0;
        #1;
        d = regRdata;
    endtask

    task automatic fill(input logic [63:0] v, input logic l);
        @(posedge clk);
        fillValid <= 1'h1;
        fillData <= v;
        fillLast <= l;
        @(posedge clk);
        fillValid <= 1'h0;
        #1;
    endtask

    // bounded wait, entered just after an edge
    task automatic wait_high(ref logic s);
        int k;
        k = 0;
        #1;
        while (s !== 1'h1 && k < 40)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic drain(input int n);
        int k;
        k = 0;
        log_q.delete();
        @(posedge clk);
        popEn <= 1'h1;
        while (log_q.size() < n && k < 200)
        begin
            @(posedge clk);
            k++;
        end
        popEn <= 1'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset;
        #1;
        chk({master_read_empty_n, master_read_almost_empty_n, master_read_last_n}, 3'h1);
        chk(fillReady, 1'h1);
        rd(`ADDR_STATUS);
        chk(d[6:0], 7'h04);
        rd(4'h2);
        chk(d, 32'h0);
        wait_high(target_side_ready);
        chk(target_side_ready, 1'h1);
        $display("test reset done");
    endtask

    task automatic t_quad;
        for (int i = 0; i < 5; i++)
        begin
            fill(64'h0123_4567_89AB_CDEF * (i + 1), i == 4);
            chk({master_read_empty_n, master_read_almost_empty_n}, {1'h1, i == 4});
        end
        drain(20);
        for (int i = 0; i < 20; i++)
        begin
            w = 64'h0123_4567_89AB_CDEF * (i / 4 + 1);
            chk(log_q[i][50:32], {i != 19, 2'h0, w[16 * (i % 4) +: 16]});
        end
        chk(master_read_empty_n, 1'h0);
        $display("test quad done");
    endtask

    task automatic t_dual;
        wr(`ADDR_CTRL, 32'h0);
        fill(64'hFEDC_BA98_7654_3210, 1'h0);
        fill(64'h1357_9BDF_2468_ACE0, 1'h1);
        drain(4);
        for (int i = 0; i < 4; i++)
        begin
            w = (i < 2) ? 64'hFEDC_BA98_7654_3210 : 64'h1357_9BDF_2468_ACE0;
            chk({log_q[i][50], log_q[i][31:0]}, {i != 3, w[32 * (i % 2) +: 32]});
        end
        // dual bus released to other traffic while fifo_select is high
        @(posedge clk);
        fifo_select <= 1'h1;
        #1;
        chk({dualReadData, dualReadDataX}, 36'h0);
        @(posedge clk);
        fifo_select <= 1'h0;
        wr(`ADDR_CTRL, `CTRL_RESET);
        $display("test dual done");
    endtask

    task automatic t_burst;
        @(posedge clk);
        cmdValid <= 1'h1;
        cmdQuad <= 18'h20000;
        @(posedge clk);
        cmdQuad <= 18'h01234;
        @(posedge clk);
        cmdValid <= 1'h0;
        wait_high(burstLengthValid);
        chk(burstLength, 18'h21234);
        wr(`ADDR_CTRL, 32'h0);
        @(posedge clk);
        cmdValid <= 1'h1;
        // four side bits beside main bus
        cmdDualX <= 4'h1;
        cmdDual <= 32'h0000_5678;
        @(posedge clk);
        cmdValid <= 1'h0;
        wait_high(burstLengthValid);
        chk(burstLength, 18'h15678);
        // clock b selected but idle: the command is not taken
        wr(`ADDR_CTRL, 32'h2);
        @(posedge clk);
        cmdValid <= 1'h1;
        cmdDual <= 32'h0000_0ABC;
        @(posedge clk);
        cmdValid <= 1'h0;
        #1;
        chk(burstLengthValid, 1'h0);
        rd(`ADDR_BURST);
        chk(d[17:0], 18'h15678);
        @(posedge clk);
        {fabric_clock_a, fabric_clock_b, cmdValid} <= 3'h3;
        @(posedge clk);
        cmdValid <= 1'h0;
        wait_high(burstLengthValid);
        chk(burstLength, 18'h10ABC);
        @(posedge clk);
        {fabric_clock_a, fabric_clock_b} <= 2'h2;
        wr(`ADDR_CTRL, `CTRL_RESET);
        $display("test burst done");
    endtask

    // stop check helper: drive, wait, compare
    task automatic stop_step(input logic s, input logic m, input int n, input logic e);
        @(posedge clk);
        read_burst_stop_n <= s;
        masterTransferring <= m;
        repeat (n) @(posedge clk);
        #1;
        chk(burstStopReq, e);
    endtask

    task automatic t_stop;
        stop_step(1'h0, 1'h1, 0, 1'h0);
        stop_step(1'h1, 1'h1, 3, 1'h0);
        stop_step(1'h0, 1'h1, 3, 1'h1);
        stop_step(1'h0, 1'h0, 3, 1'h0);
        stop_step(1'h1, 1'h0, 1, 1'h0);
        $display("test stop done");
    endtask

    task automatic t_target;
        @(posedge clk);
        target_retry_n <= 1'h0;
        delayed_txn_n <= 1'h0;
        targetPendN <= 1'h0;
        // steps taken without waiting on ready
        targetStep <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk({retryActive, delayedActive}, 2'h3);
        chk(target_state_count != 4'h0, 1'h1);
        @(posedge clk);
        target_fifo_clear_n <= 1'h0;
        #1;
        chk({target_state_count, target_side_ready}, 5'h0);
        @(posedge clk);
        {target_fifo_clear_n, target_retry_n, delayed_txn_n, targetPendN} <= 4'hF;
        targetStep <= 1'h0;
        wait_high(target_side_ready);
        chk({target_side_ready, retryActive, delayedActive}, 3'h4);
        @(posedge clk);
        pciRstN <= 1'h0;
        #1;
        chk(target_side_ready, 1'h0);
        @(posedge clk);
        pciRstN <= 1'h1;
        wait_high(target_side_ready);
        chk(target_side_ready, 1'h1);
        $display("test target done");
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run;
    end

    initial
    begin
        {rst_n, regWrite, regRead, fabric_clock_b, fillValid, fillLast, popEn} = 7'h0;
        {masterTransferring, fifo_select, cmdValid, targetStep, targetDone} = 5'h0;
        {fabric_clock_a, pciClkEn, pciRstN, read_burst_stop_n} = 4'hF;
        {target_retry_n, delayed_txn_n, target_fifo_clear_n, targetPendN} = 4'hF;
        {regAddr, regWdata, fillData, cmdQuad, cmdDualX, cmdDual} = '0;
        num_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_reset;
        t_quad;
        t_dual;
        t_burst;
        t_stop;
        t_target;
        complete_run;
    end
endmodule

bind pci_read_fifo_target_ctl read_fifo_monitor #(.DEPTH(DEPTH)) read_fifo_monitor_i (.*);
